// *** slot_power_consts.svh ***
`ifndef SLOT_POWER_CONSTS_SVH
`define SLOT_POWER_CONSTS_SVH

// Clock and timing
`define CLK_MHZ             50
`define POR_DELAY_US        20000
`define POR_DELAY_CYCLES    (`POR_DELAY_US * `CLK_MHZ)
`define OC_FILTER_US        10
`define OC_FILTER_CYCLES    (`OC_FILTER_US * `CLK_MHZ)

// Register byte offsets
`define OFS_CTRL_A          5'h00
`define OFS_CTRL_B          5'h04
`define OFS_STAT_A          5'h08
`define OFS_STAT_B          5'h0C
`define OFS_COMMON          5'h10

// Slot control fields
`define CTRL_MAIN_ON        0
`define CTRL_AUX_ON         1
`define CTRL_FORCE_DIS      2
`define CTRL_RESET          3'h0

// Slot status fields
`define STAT_MAIN_ON        0
`define STAT_AUX_ON         1
`define STAT_MAIN_FLT       2
`define STAT_AUX_FLT        3
`define STAT_PGOOD          4
`define STAT_FORCED         5
`define STAT_STBY_OK        6

// Common status fields
`define CS_POR_DONE         0
`define CS_IRQ_MASK         3
`define CS_GP_A             4
`define CS_GP_B             5
`define CS_MASK_RESET       1'b0

// Positions of two-bit slot groups in the synchroniser vector
`define IX_MAIN_EN          0
`define IX_AUX_EN           1
`define IX_STBY             2
`define IX_LIM12            3
`define IX_LIM3             4
`define IX_MAIN_UV          5
`define IX_MAIN_OT          6
`define IX_MAIN_PG          7
`define IX_AUX_LIM          8
`define IX_AUX_OT           9
`define IX_AUX_PG           10
`define IX_FORCE            11
`define IX_GP               12
`define SYNC_W              26

`endif

// *** slot_power_pkg.sv ***
package slot_power_pkg;
    typedef logic [1:0]  slot_vec_t;
    typedef logic [31:0] word_t;
    typedef logic [2:0]  ctrl_t;
    typedef logic [19:0] oc_cnt_t;
endpackage

// *** dual_slot_power_enable_fault_logic.sv ***
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "slot_power_consts.svh"

module dual_slot_power_enable_fault_logic
    import slot_power_pkg::*;
#(
    parameter int unsigned POR_CYCLES  = `POR_DELAY_CYCLES,
    parameter int unsigned OC_FILTER_A = `OC_FILTER_CYCLES,
    parameter int unsigned OC_FILTER_B = `OC_FILTER_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    input  wire logic [1:0]  main_enable_in,
    input  wire logic [1:0]  aux_enable_in,
    input  wire logic [1:0]  force_on_n,
    input  wire logic [1:0]  standby_supply,
    input  wire logic [1:0]  main_limit_12v,
    input  wire logic [1:0]  main_limit_3v,
    input  wire logic [1:0]  main_input_uv,
    input  wire logic [1:0]  main_overtemp,
    input  wire logic [1:0]  main_output_ok,
    input  wire logic [1:0]  aux_limit,
    input  wire logic [1:0]  aux_overtemp,
    input  wire logic [1:0]  aux_output_ok,
    input  wire logic        gp_input_slot_a,
    input  wire logic        gp_input_slot_b,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [1:0]  main_rails_slot,
    output logic      [1:0]  aux_rail_out,
    output logic      [1:0]  power_good_n,
    output logic      [1:0]  fault_n,
    output logic             irq_n
);

    localparam int unsigned POR_W = $clog2(POR_CYCLES + 1);

    logic [`SYNC_W-1:0] raw;
    logic [`SYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;

    logic [POR_W-1:0] por_cnt_reg, por_cnt_next;
    logic             por_done_reg, por_done_next;
    slot_vec_t        main_en_d_reg, main_en_d_next, aux_en_d_reg, aux_en_d_next;
    slot_vec_t        main_req_reg, main_req_next, aux_req_reg, aux_req_next;
    slot_vec_t        main_flt_reg, main_flt_next, aux_flt_reg, aux_flt_next;
    slot_vec_t        main_on_reg, main_on_next, aux_on_reg, aux_on_next;
    slot_vec_t        pg_true_reg, pg_true_next, forced_reg, forced_next;
    slot_vec_t        pg_n_reg, pg_n_next, flt_n_reg, flt_n_next;
    oc_cnt_t          main_oc_reg [2], main_oc_next [2], aux_oc_reg [2], aux_oc_next [2];
    ctrl_t            ctrl_reg [2], ctrl_next [2];
    logic             mask_reg, mask_next, irq_n_reg, irq_n_next, wait_reg, wait_next;
    word_t            rdata_reg, rdata_next;

    slot_vec_t main_en, aux_en, stby, main_lim, main_uv, main_ot, main_pg;
    slot_vec_t aux_lim, aux_ot, aux_pg, force_in, main_rise, aux_rise;
    slot_vec_t main_trip, aux_trip, main_clr_wr, aux_clr_wr;
    logic      wr_go, rd_go;

    function automatic slot_vec_t grp(input logic [`SYNC_W-1:0] v, input int idx);
        grp = v[2*idx +: 2];
    endfunction
    function automatic oc_cnt_t oc_limit(input int s);
        oc_limit = (s == 0) ? oc_cnt_t'(OC_FILTER_A - 1) : oc_cnt_t'(OC_FILTER_B - 1);
    endfunction
    function automatic int unsigned stat_ofs(input int s);
        stat_ofs = (s == 0) ? `OFS_STAT_A : `OFS_STAT_B;
    endfunction
    function automatic int unsigned ctrl_ofs(input int s);
        ctrl_ofs = (s == 0) ? `OFS_CTRL_A : `OFS_CTRL_B;
    endfunction

    // Force-on is inverted ahead of the first flop so that reset means released
    assign raw = {gp_input_slot_b, gp_input_slot_a, ~force_on_n, aux_output_ok, aux_overtemp,
                  aux_limit, main_output_ok, main_overtemp, main_input_uv, main_limit_3v,
                  main_limit_12v, standby_supply, aux_enable_in, main_enable_in};

    // Three-stage synchroniser with agreement filter
    always_comb begin
        filt_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            filt_reg <= '0;
        end else if (clk_en) begin
            s1_reg   <= raw;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= filt_next;
        end
    end

    assign main_en  = grp(filt_reg, `IX_MAIN_EN);
    assign aux_en   = grp(filt_reg, `IX_AUX_EN);
    assign stby     = grp(filt_reg, `IX_STBY);
    assign main_lim = grp(filt_reg, `IX_LIM12) | grp(filt_reg, `IX_LIM3);
    assign main_uv  = grp(filt_reg, `IX_MAIN_UV);
    assign main_ot  = grp(filt_reg, `IX_MAIN_OT);
    assign main_pg  = grp(filt_reg, `IX_MAIN_PG);
    assign aux_lim  = grp(filt_reg, `IX_AUX_LIM);
    assign aux_ot   = grp(filt_reg, `IX_AUX_OT);
    assign aux_pg   = grp(filt_reg, `IX_AUX_PG);
    assign force_in = grp(filt_reg, `IX_FORCE);
    assign wr_go = avs_write && !wait_reg;
    assign rd_go = avs_read && wait_reg;

    always_comb begin
        por_cnt_next   = por_cnt_reg;
        por_done_next  = por_done_reg;
        main_en_d_next = main_en;
        aux_en_d_next  = aux_en;
        mask_next      = mask_reg;
        ctrl_next      = ctrl_reg;
        // Power-on delay restarts whenever either standby input drops
        if (!(&stby)) begin
            por_cnt_next  = '0;
            por_done_next = 1'b0;
        end else if (por_cnt_reg == POR_W'(POR_CYCLES - 1)) begin
            por_done_next = 1'b1;
        end else begin
            por_cnt_next = por_cnt_reg + POR_W'(1);
        end
        if (wr_go && avs_byteenable[0]) begin
            for (int s = 0; s < 2; s++) begin
                if (avs_address == 5'(ctrl_ofs(s))) begin
                    ctrl_next[s] = avs_writedata[2:0];
                end
            end
            if (avs_address == `OFS_COMMON) begin
                mask_next = avs_writedata[`CS_IRQ_MASK];
            end
        end
        for (int s = 0; s < 2; s++) begin
            main_rise[s]   = main_en[s] && !main_en_d_reg[s];
            aux_rise[s]    = aux_en[s] && !aux_en_d_reg[s];
            forced_next[s] = force_in[s] && !ctrl_reg[s][`CTRL_FORCE_DIS];
            main_clr_wr[s] = wr_go && avs_byteenable[0] && avs_address == 5'(stat_ofs(s))
                             && avs_writedata[`STAT_MAIN_FLT];
            aux_clr_wr[s]  = wr_go && avs_byteenable[0] && avs_address == 5'(stat_ofs(s))
                             && avs_writedata[`STAT_AUX_FLT];
            // Continuous current-limit timers, bypassed while forced
            main_oc_next[s] = (main_lim[s] && main_on_reg[s] && !forced_next[s])
                              ? main_oc_reg[s] + oc_cnt_t'(1) : '0;
            aux_oc_next[s]  = (aux_lim[s] && aux_on_reg[s] && !forced_next[s])
                              ? aux_oc_reg[s] + oc_cnt_t'(1) : '0;
            main_trip[s] = !forced_next[s] && main_on_reg[s] && ((main_lim[s]
                           && main_oc_reg[s] == oc_limit(s)) || main_uv[s] || main_ot[s]);
            aux_trip[s]  = !forced_next[s] && aux_on_reg[s] && ((aux_lim[s]
                           && aux_oc_reg[s] == oc_limit(s)) || aux_ot[s]);
            // Set beats clear; enable-low or echo write clears
            main_flt_next[s] = main_trip[s] || (main_flt_reg[s] && main_en[s]
                               && !main_clr_wr[s]);
            aux_flt_next[s]  = aux_trip[s] || (aux_flt_reg[s] && aux_en[s]
                               && !aux_clr_wr[s]);
            if (!por_done_reg || main_trip[s] || !main_en[s]) begin
                main_req_next[s] = 1'b0;
            end else if (main_rise[s]) begin
                main_req_next[s] = 1'b1;
            end else begin
                main_req_next[s] = main_req_reg[s];
            end
            if (!por_done_reg || aux_trip[s] || !aux_en[s]) begin
                aux_req_next[s] = 1'b0;
            end else if (aux_rise[s]) begin
                aux_req_next[s] = 1'b1;
            end else begin
                aux_req_next[s] = aux_req_reg[s];
            end
            ctrl_next[s][`CTRL_MAIN_ON] = ctrl_next[s][`CTRL_MAIN_ON] && !main_trip[s];
            ctrl_next[s][`CTRL_AUX_ON]  = ctrl_next[s][`CTRL_AUX_ON] && !aux_trip[s];
            // Both main rails share one switch state
            main_on_next[s] = forced_next[s] || (!main_flt_next[s] && !main_uv[s]
                              && (main_req_next[s] || (por_done_reg
                              && ctrl_next[s][`CTRL_MAIN_ON])));
            aux_on_next[s]  = stby[s] && (forced_next[s] || (!aux_flt_next[s]
                              && (aux_req_next[s] || (por_done_reg
                              && ctrl_next[s][`CTRL_AUX_ON]))));
            pg_true_next[s] = main_on_next[s] && aux_on_next[s] && main_pg[s] && aux_pg[s];
            pg_n_next[s]    = forced_next[s] || !pg_true_next[s];
            flt_n_next[s]   = forced_next[s] || !(main_flt_next[s] || aux_flt_next[s]);
        end
        irq_n_next = !(((|main_flt_next) || (|aux_flt_next)) && !mask_next);
    end

    // Avalon slave: one wait cycle, then a single acknowledge cycle
    always_comb begin
        wait_next  = 1'b1;
        rdata_next = rdata_reg;
        if ((avs_read || avs_write) && wait_reg) begin
            wait_next = 1'b0;
        end
        if (rd_go) begin
            rdata_next = '0;
            for (int s = 0; s < 2; s++) begin
                if (avs_address == 5'(ctrl_ofs(s))) begin
                    rdata_next[2:0] = ctrl_reg[s];
                end
                if (avs_address == 5'(stat_ofs(s))) begin
                    rdata_next[`STAT_MAIN_ON]  = main_on_reg[s];
                    rdata_next[`STAT_AUX_ON]   = aux_on_reg[s];
                    rdata_next[`STAT_MAIN_FLT] = main_flt_reg[s];
                    rdata_next[`STAT_AUX_FLT]  = aux_flt_reg[s];
                    rdata_next[`STAT_PGOOD]    = pg_true_reg[s];
                    rdata_next[`STAT_FORCED]   = forced_reg[s];
                    rdata_next[`STAT_STBY_OK]  = stby[s];
                end
            end
            if (avs_address == `OFS_COMMON) begin
                rdata_next[`CS_POR_DONE] = por_done_reg;
                rdata_next[`CS_IRQ_MASK] = mask_reg;
                rdata_next[`CS_GP_A]     = filt_reg[2*`IX_GP];
                rdata_next[`CS_GP_B]     = filt_reg[2*`IX_GP+1];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            por_cnt_reg   <= '0;
            por_done_reg  <= 1'b0;
            main_en_d_reg <= '0;
            aux_en_d_reg  <= '0;
            main_req_reg  <= '0;
            aux_req_reg   <= '0;
            main_flt_reg  <= '0;
            aux_flt_reg   <= '0;
            main_on_reg   <= '0;
            aux_on_reg    <= '0;
            pg_true_reg   <= '0;
            forced_reg    <= '0;
            pg_n_reg      <= 2'h3;
            flt_n_reg     <= 2'h3;
            main_oc_reg   <= '{default: '0};
            aux_oc_reg    <= '{default: '0};
            ctrl_reg      <= '{default: `CTRL_RESET};
            mask_reg      <= `CS_MASK_RESET;
            irq_n_reg     <= 1'b1;
            wait_reg      <= 1'b1;
            rdata_reg     <= '0;
        end else if (clk_en) begin
            por_cnt_reg   <= por_cnt_next;
            por_done_reg  <= por_done_next;
            main_en_d_reg <= main_en_d_next;
            aux_en_d_reg  <= aux_en_d_next;
            main_req_reg  <= main_req_next;
            aux_req_reg   <= aux_req_next;
            main_flt_reg  <= main_flt_next;
            aux_flt_reg   <= aux_flt_next;
            main_on_reg   <= main_on_next;
            aux_on_reg    <= aux_on_next;
            pg_true_reg   <= pg_true_next;
            forced_reg    <= forced_next;
            pg_n_reg      <= pg_n_next;
            flt_n_reg     <= flt_n_next;
            main_oc_reg   <= main_oc_next;
            aux_oc_reg    <= aux_oc_next;
            ctrl_reg      <= ctrl_next;
            mask_reg      <= mask_next;
            irq_n_reg     <= irq_n_next;
            wait_reg      <= wait_next;
            rdata_reg     <= rdata_next;
        end
    end

    assign main_rails_slot = main_on_reg;
    assign aux_rail_out    = aux_on_reg;
    assign power_good_n    = pg_n_reg;
    assign fault_n         = flt_n_reg;
    assign irq_n           = irq_n_reg;
    assign avs_waitrequest = wait_reg;
    assign avs_readdata    = rdata_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    for (genvar g = 0; g < 2; g++) begin : g_chk
        sequence main_armed;
            clk_en && por_done_reg && main_rise[g] && !main_trip[g];
        endsequence
        a_main_edge_on: assert property (main_armed |=> main_req_reg[g])
            else $error("main request missing after enable edge");
        a_main_low_off: assert property (clk_en && !main_en[g] |=> !main_req_reg[g])
            else $error("main request held with enable low");
        a_aux_edge_on: assert property ($rose(aux_req_reg[g]) |-> $past(aux_rise[g]
            && por_done_reg))
            else $error("aux request without armed edge");
        a_main_flt_clear: assert property (clk_en && !main_en[g] && !main_trip[g]
            |=> !main_flt_reg[g])
            else $error("main fault not cleared by enable low");
        a_aux_flt_clear: assert property (clk_en && !aux_en[g] && !aux_trip[g]
            |=> !aux_flt_reg[g])
            else $error("aux fault not cleared by enable low");
        a_oc_filter_wait: assert property (main_trip[g] && !main_uv[g] && !main_ot[g]
            |-> main_oc_reg[g] == oc_limit(g))
            else $error("breaker tripped before filter delay");
        a_force_pins_idle: assert property (forced_reg[g] |-> power_good_n[g]
            && fault_n[g] && main_rails_slot[g])
            else $error("forced slot drove status pins");
        a_fault_pin_low: assert property (!forced_reg[g] && (main_flt_reg[g] || aux_flt_reg[g])
            |-> !fault_n[g] && !(main_flt_reg[g] && main_rails_slot[g])
            && !(aux_flt_reg[g] && aux_rail_out[g]))
            else $error("fault pin or rails wrong on fault");
        a_aux_standby: assert property (aux_rail_out[g] |-> $past(stby[g]))
            else $error("aux on without standby");
    end

    a_irq_mask: assert property (irq_n == (mask_reg
        || !(|main_flt_reg || |aux_flt_reg)))
        else $error("interrupt level disagrees with unmasked faults");

endmodule // dual_slot_power_enable_fault_logic

// *** slot_rail_model.sv ***
`timescale 1ns/1ps

module slot_rail_model (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       slow,
    input  wire logic [1:0] main_on,
    input  wire logic [1:0] aux_on,
    output logic      [1:0] main_ok,
    output logic      [1:0] aux_ok
);
    logic [3:0] ramp_reg [4];
    logic [3:0] on;
    logic [3:0] ok;
    logic [3:0] need;

    assign on = {aux_on, main_on};
    assign need = slow ? 4'h9 : 4'h2;
    assign main_ok = ok[1:0];
    assign aux_ok = ok[3:2];

    // Rails ramp up after switch-on and collapse at once when switched off
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ramp_reg <= '{default: 4'h0};
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (!on[i]) begin
                    ramp_reg[i] <= 4'h0;
                end else if (ramp_reg[i] != 4'hf) begin
                    ramp_reg[i] <= ramp_reg[i] + 4'h1;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ok[i] = on[i] && (ramp_reg[i] >= need);
        end
    end
endmodule // slot_rail_model

// *** testbench.sv ***
`timescale 1ns/1ps
`include "slot_power_consts.svh"

module testbench
    import slot_power_pkg::*;
;
    logic      clk;
    logic      arst_n;
    logic      clk_en;
    slot_vec_t main_enable_in, aux_enable_in, force_on_n, standby_supply;
    slot_vec_t main_limit_12v, main_limit_3v, main_input_uv, main_overtemp;
    slot_vec_t aux_limit, aux_overtemp, main_output_ok, aux_output_ok;
    slot_vec_t main_rails_slot, aux_rail_out, power_good_n, fault_n;
    logic      gp_input_slot_a, gp_input_slot_b, avs_read, avs_write, slow;
    logic      avs_waitrequest, irq_n;
    logic [4:0] avs_address;
    logic [3:0] avs_byteenable;
    word_t     avs_writedata, avs_readdata, rd, outs;
    int        error_cnt, n_checks, seed;

    assign outs = {23'h0, irq_n, fault_n, power_good_n, aux_rail_out, main_rails_slot};

    dual_slot_power_enable_fault_logic #(
        .POR_CYCLES  (20),
        .OC_FILTER_A (4),
        .OC_FILTER_B (4)
    ) u_dual_slot_power_enable_fault_logic (
        .clk, .arst_n, .clk_en, .main_enable_in, .aux_enable_in, .force_on_n,
        .standby_supply, .main_limit_12v, .main_limit_3v, .main_input_uv,
        .main_overtemp, .main_output_ok, .aux_limit, .aux_overtemp, .aux_output_ok,
        .gp_input_slot_a, .gp_input_slot_b, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .main_rails_slot, .aux_rail_out, .power_good_n, .fault_n, .irq_n
    );

    slot_rail_model u_slot_rail_model (
        .clk, .arst_n, .slow, .main_on(main_rails_slot), .aux_on(aux_rail_out),
        .main_ok(main_output_ok), .aux_ok(aux_output_ok)
    );

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    function automatic word_t exp_common(input logic ga, input logic gb, input logic msk);
        return {26'h0, gb, ga, msk, 2'h0, 1'h1};
    endfunction

    function automatic word_t exp_stat(input logic [6:0] f);
        return {25'h0, f};
    endfunction

    task automatic check(input string what, input word_t seen, input word_t exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic bus(input logic wr, input logic [4:0] adr, input word_t d);
        avs_address <= adr;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'h0) begin
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge clk);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        tick(5000);
        error_cnt++;
        complete_run();
    end

    initial begin
        seed = 96147;
        error_cnt = 0;
        n_checks = 0;
        {arst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {main_enable_in, aux_enable_in, main_limit_12v, main_limit_3v} = '0;
        {main_input_uv, main_overtemp, aux_limit, aux_overtemp} = '0;
        {force_on_n, standby_supply, avs_byteenable, clk_en} = '1;
        rd = $random(seed);
        {gp_input_slot_b, gp_input_slot_a, slow} = rd[2:0];
        tick(8);
        arst_n <= 1'h1;
        main_enable_in <= 2'h1;
        tick(10);
        check("reset pins", outs, 32'h1f0);
        tick(40);
        check("no edge", outs, 32'h1f0);
        bus(1'h0, `OFS_COMMON, 32'h0);
        check("common", rd, exp_common(gp_input_slot_a, gp_input_slot_b, 1'h0));
        main_enable_in <= 2'h0;
        tick(10);
        main_enable_in <= 2'h1;
        aux_enable_in <= 2'h1;
        tick(30);
        check("power on", outs, 32'h1e5);
        bus(1'h0, `OFS_STAT_A, 32'h0);
        check("stat on", rd, exp_stat(7'h53));
        main_limit_12v <= 2'h1;
        tick(2);
        main_limit_12v <= 2'h0;
        tick(10);
        check("short limit", outs, 32'h1e5);
        main_limit_12v <= 2'h1;
        tick(20);
        main_limit_12v <= 2'h0;
        check("trip", outs, 32'h0b4);
        bus(1'h0, `OFS_STAT_A, 32'h0);
        check("stat trip", rd, exp_stat(7'h46));
        bus(1'h1, `OFS_STAT_A, 32'h4);
        tick(2);
        check("irq echo", word_t'(irq_n), 32'h1);
        bus(1'h1, `OFS_COMMON, 32'h8);
        main_enable_in <= 2'h0;
        tick(10);
        main_enable_in <= 2'h1;
        tick(30);
        check("re-arm", outs, 32'h1e5);
        main_overtemp <= 2'h1;
        tick(10);
        main_overtemp <= 2'h0;
        check("masked trip", outs, 32'h1b4);
        main_enable_in <= 2'h0;
        tick(10);
        check("main clear", outs, 32'h1f4);
        bus(1'h0, `OFS_STAT_A, 32'h0);
        check("stat clear", rd, exp_stat(7'h42));
        aux_overtemp <= 2'h1;
        tick(10);
        aux_overtemp <= 2'h0;
        check("aux trip", outs, 32'h1b0);
        aux_enable_in <= 2'h0;
        tick(10);
        check("aux clear", outs, 32'h1f0);
        force_on_n <= 2'h1;
        tick(30);
        main_limit_3v <= 2'h2;
        check("force", outs, 32'h1fa);
        tick(20);
        main_limit_3v <= 2'h0;
        check("force limit", outs, 32'h1fa);
        bus(1'h0, `OFS_STAT_B, 32'h0);
        check("stat force", rd, exp_stat(7'h73));
        bus(1'h1, `OFS_CTRL_B, 32'h4);
        tick(10);
        check("force off", outs, 32'h1f0);
        bus(1'h0, `OFS_CTRL_B, 32'h0);
        check("ctrl b", rd, 32'h4);
        clk_en <= 1'h0;
        force_on_n <= 2'h2;
        tick(10);
        check("frozen", outs, 32'h1f0);
        clk_en <= 1'h1;
        tick(10);
        check("force a", outs, 32'h1f5);
        force_on_n <= 2'h3;
        for (int i = 0; i < 4; i++) begin
            rd = $random(seed);
            gp_input_slot_a <= rd[0];
            gp_input_slot_b <= rd[1];
            tick(8);
            bus(1'h0, `OFS_COMMON, 32'h0);
            check("gp", rd, exp_common(gp_input_slot_a, gp_input_slot_b, 1'h1));
        end
        bus(1'h0, 5'h14, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(1'h1, `OFS_CTRL_A, 32'h3);
        tick(10);
        check("serial on", word_t'({aux_rail_out, main_rails_slot}), 32'h5);
        standby_supply <= 2'h0;
        tick(10);
        check("standby off", word_t'(aux_rail_out), 32'h0);
        complete_run();
    end
endmodule // testbench
